// ==== rtl/aic_regs.svh ====
// constants for the amplifier control link
`ifndef AIC_REGS_SVH
`define AIC_REGS_SVH

// ==========================================
// chip address
`define AIC_ADDR_FIXED     6'h36
`define AIC_ADDR_WRITE     1'h0

// ==========================================
// framing counts
`define AIC_BIT_LAST       3'h7
`define AIC_ACK_SLOT       4'h8
`define AIC_WAKE_BITS      4

// ==========================================
// timing
`define AIC_CORE_HZ        10000000
`define AIC_SCL_MAX_HZ     400000
`define AIC_QUARTER_CYCLES ((`AIC_CORE_HZ + 4 * `AIC_SCL_MAX_HZ - 1) / (4 * `AIC_SCL_MAX_HZ))

`endif

// ==== rtl/aic_pkg.sv ====
// types shared by both ends of the amplifier control link
package aic_pkg;

    // ==========================================
    // device end, link side
    typedef enum logic [2:0] {
        DS_IDLE,
        DS_ADDR,
        DS_ACK_ADDR,
        DS_DATA,
        DS_ACK_DATA,
        DS_IGNORE
    } aic_dev_state_type;

    // ==========================================
    // host end
    typedef enum logic [2:0] {
        HS_WAKE,
        HS_IDLE,
        HS_START,
        HS_BIT,
        HS_STOP
    } aic_host_state_type;

endpackage

// ==== rtl/aic_bus_if.sv ====
// two-wire control bus joining host end and device end
`timescale 1ns/100ps

interface aic_bus_if;
    logic scl;
    logic host_sda_oe;
    logic dev_sda_oe;
    logic sda;

    // wired-and with pull-up: any enable pulls the line low
    assign sda = ~(host_sda_oe | dev_sda_oe);

    modport host (
        output scl,
        output host_sda_oe,
        input  sda
    );

    modport dev (
        input  scl,
        input  sda,
        output dev_sda_oe
    );
endinterface // aic_bus_if

// ==== rtl/aic_sync.sv ====
// two-stage synchroniser for levels entering a clock domain
`timescale 1ns/100ps

module aic_sync
    import aic_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stage_q;

    // ==========================================
    // capture chain
    always_ff @(posedge clk)
    begin
        meta_q  <= d;
        stage_q <= meta_q;
    end

    assign q = stage_q;

endmodule // aic_sync

// ==== rtl/aic_dev_end.sv ====
// device end: write-only control slave clocked by the serial clock
`timescale 1ns/100ps
`include "aic_regs.svh"

// Summary of operation
// R1 - answer only address 110110, select bit, 0
// R2 - select bit follows the identity strap level
// R3 - host keeps serial clock at most 400kHz
// R4 - data falling while clock high starts frame
// R5 - eight address bits, msb first, rising edge
// R6 - host holds address bits steady during high
// R7 - matched address acknowledged by pulling data low
// R8 - host abandons transfer on missing address acknowledge
// R9 - data bytes eight bits, msb first, sampled high
// R10 - every data byte acknowledged low; host checks
// R11 - unlimited bytes accepted until stop condition
// R12 - data rising while clock high ends frame
// R13 - host leaves data line released when idle
// R14 - clock input only; data pulled down only
// R15 - mismatch stays silent; bytes go to decoder
module aic_dev_end
    import aic_pkg::*;
(
    aic_bus_if.dev      bus,
    input  wire logic   core_clk,
    input  wire logic   reset,
    input  wire logic   chip_identity_strap,
    output logic [7:0]  rx_byte,
    output logic        rx_valid
);

    // ==========================================
    // address compare
    function automatic logic addr_match(input logic [7:0] addr, input logic strap);
        addr_match = (addr == {`AIC_ADDR_FIXED, strap, `AIC_ADDR_WRITE});
    endfunction

    logic              link_rst;
    logic              strap_s;
    logic              start_tgl_q;
    logic              start_tgl_d;
    logic              stop_tgl_q;
    logic              stop_tgl_d;
    aic_dev_state_type state_q;
    aic_dev_state_type state_d;
    logic [2:0]        cnt_q;
    logic [2:0]        cnt_d;
    logic [7:0]        shift_q;
    logic [7:0]        shift_d;
    logic              start_seen_q;
    logic              start_seen_d;
    logic              stop_seen_q;
    logic              stop_seen_d;
    logic [7:0]        byte_q;
    logic [7:0]        byte_d;
    logic              byte_tgl_q;
    logic              byte_tgl_d;
    logic              ack_oe_q;
    logic              ack_oe_d;
    logic              byte_tgl_s;
    logic              tgl_seen_q;
    logic              tgl_seen_d;
    logic [7:0]        rx_byte_q;
    logic [7:0]        rx_byte_d;
    logic              rx_valid_q;
    logic              rx_valid_d;
    logic [7:0]        shifted;

    // ==========================================
    // link reset and strap into the serial clock domain
    aic_sync #(
        .WIDTH (2)
    ) u_link_sync (
        .clk (bus.scl),
        .d   ({reset, chip_identity_strap}),
        .q   ({link_rst, strap_s})
    );

    // ==========================================
    // start and stop detection on data edges
    // each event flips a toggle; the link side compares against its copy
    always_comb
    begin
        start_tgl_d = start_tgl_q;
        if (link_rst)
            start_tgl_d = 1'h0;
        else if (bus.scl)
            start_tgl_d = ~start_tgl_q;             // [R4]
    end

    always_ff @(negedge bus.sda)
    begin
        start_tgl_q <= start_tgl_d;
    end

    always_comb
    begin
        stop_tgl_d = stop_tgl_q;
        if (link_rst)
            stop_tgl_d = 1'h0;
        else if (bus.scl)
            stop_tgl_d = ~stop_tgl_q;               // [R12]
    end

    always_ff @(posedge bus.sda)
    begin
        stop_tgl_q <= stop_tgl_d;
    end

    // ==========================================
    // receive state, sampled on rising clock
    assign shifted = {shift_q[6:0], bus.sda};

    always_comb
    begin
        state_d      = state_q;
        cnt_d        = cnt_q;
        shift_d      = shift_q;
        start_seen_d = start_seen_q;
        stop_seen_d  = stop_seen_q;
        byte_d       = byte_q;
        byte_tgl_d   = byte_tgl_q;
        if (link_rst)
        begin
            state_d      = DS_IDLE;
            cnt_d        = 3'h0;
            shift_d      = 8'h00;
            start_seen_d = 1'h0;
            stop_seen_d  = 1'h0;
            byte_d       = 8'h00;
            byte_tgl_d   = 1'h0;
        end
        else if (start_tgl_q != start_seen_q)
        begin
            // start wins over a stop seen in the same gap
            start_seen_d = start_tgl_q;
            stop_seen_d  = stop_tgl_q;
            state_d      = DS_ADDR;                 // [R4]
            shift_d      = {7'h00, bus.sda};        // [R5]
            cnt_d        = 3'h1;
        end
        else if (stop_tgl_q != stop_seen_q)
        begin
            stop_seen_d = stop_tgl_q;
            state_d     = DS_IDLE;                  // [R12]
        end
        else
        begin
            unique case (state_q)
                DS_IDLE:
                    state_d = DS_IDLE;
                DS_IGNORE:
                    state_d = DS_IGNORE;            // [R15]
                DS_ADDR:
                begin
                    shift_d = shifted;              // [R5]
                    cnt_d   = cnt_q + 3'h1;
                    if (cnt_q == `AIC_BIT_LAST)
                    begin
                        cnt_d = 3'h0;
                        if (addr_match(shifted, strap_s))   // [R1] [R2]
                            state_d = DS_ACK_ADDR;
                        else
                            state_d = DS_IGNORE;    // [R15]
                    end
                end
                DS_ACK_ADDR:
                begin
                    state_d = DS_DATA;
                    cnt_d   = 3'h0;
                end
                DS_DATA:
                begin
                    shift_d = shifted;              // [R9]
                    cnt_d   = cnt_q + 3'h1;
                    if (cnt_q == `AIC_BIT_LAST)
                    begin
                        cnt_d   = 3'h0;
                        byte_d  = shifted;
                        state_d = DS_ACK_DATA;
                    end
                end
                DS_ACK_DATA:
                begin
                    byte_tgl_d = ~byte_tgl_q;       // [R15]
                    state_d    = DS_DATA;           // [R11]
                    cnt_d      = 3'h0;
                end
                default:
                    state_d = DS_IDLE;
            endcase
        end
    end

    always_ff @(posedge bus.scl)
    begin
        state_q      <= state_d;
        cnt_q        <= cnt_d;
        shift_q      <= shift_d;
        start_seen_q <= start_seen_d;
        stop_seen_q  <= stop_seen_d;
        byte_q       <= byte_d;
        byte_tgl_q   <= byte_tgl_d;
    end

    // ==========================================
    // acknowledge drive, changed on falling clock only
    always_comb
    begin
        ack_oe_d = 1'h0;
        if (!link_rst && (state_q == DS_ACK_ADDR || state_q == DS_ACK_DATA))
            ack_oe_d = 1'h1;                        // [R7] [R10]
    end

    always_ff @(negedge bus.scl)
    begin
        ack_oe_q <= ack_oe_d;
    end

    // pull-down only; the clock is never driven
    assign bus.dev_sda_oe = ack_oe_q;               // [R14]

    // ==========================================
    // byte hand-off into the core clock domain
    // byte_q is stable for at least eight serial clocks after the toggle
    aic_sync #(
        .WIDTH (1)
    ) u_byte_sync (
        .clk (core_clk),
        .d   (byte_tgl_q),
        .q   (byte_tgl_s)
    );

    always_comb
    begin
        tgl_seen_d = byte_tgl_s;
        rx_byte_d  = rx_byte_q;
        rx_valid_d = 1'h0;
        if (reset)
        begin
            tgl_seen_d = 1'h0;
            rx_byte_d  = 8'h00;
        end
        else if (byte_tgl_s != tgl_seen_q)
        begin
            rx_byte_d  = byte_q;                    // [R15]
            rx_valid_d = 1'h1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        tgl_seen_q <= tgl_seen_d;
        rx_byte_q  <= rx_byte_d;
        rx_valid_q <= rx_valid_d;
    end

    assign rx_byte  = rx_byte_q;
    assign rx_valid = rx_valid_q;

endmodule // aic_dev_end

// ==== rtl/aic_host_end.sv ====
// host end: bus master that writes control bytes to the device
`timescale 1ns/100ps
`include "aic_regs.svh"

module aic_host_end
    import aic_pkg::*;
#(
    parameter int QUARTER_CYCLES = `AIC_QUARTER_CYCLES,
    parameter int WAKE_BITS      = `AIC_WAKE_BITS
)
(
    aic_bus_if.host     bus,
    input  wire logic   core_clk,
    input  wire logic   reset,
    input  wire logic   target_id,
    input  wire logic   xfer_valid,
    input  wire logic [7:0] xfer_data,
    input  wire logic   xfer_last,
    output logic        xfer_ready,
    output logic        xfer_done,
    output logic        xfer_nack
);

    localparam int           TW        = $clog2(QUARTER_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(QUARTER_CYCLES - 1);
    localparam logic [3:0]   WAKE_LAST = 4'(WAKE_BITS - 1);

    aic_host_state_type state_q;
    aic_host_state_type state_d;
    logic [TW-1:0]      tick_q;
    logic [TW-1:0]      tick_d;
    logic [1:0]         phase_q;
    logic [1:0]         phase_d;
    logic [3:0]         bit_q;
    logic [3:0]         bit_d;
    logic [7:0]         shift_q;
    logic [7:0]         shift_d;
    logic               last_q;
    logic               last_d;
    logic               nack_q;
    logic               nack_d;
    logic               scl_q;
    logic               scl_d;
    logic               oe_q;
    logic               oe_d;
    logic               ready_q;
    logic               ready_d;
    logic               done_q;
    logic               done_d;
    logic               sda_s;
    logic               tick;

    aic_sync #(
        .WIDTH (1)
    ) u_sda_sync (
        .clk (core_clk),
        .d   (bus.sda),
        .q   (sda_s)
    );

    // ==========================================
    // quarter-bit timing; four quarters stay under the clock limit
    assign tick = (tick_q == TICK_LAST);            // [R3]

    always_comb
    begin
        state_d = state_q;
        tick_d  = tick ? '0 : tick_q + TW'(1);
        phase_d = tick ? phase_q + 2'h1 : phase_q;
        bit_d   = bit_q;
        shift_d = shift_q;
        last_d  = last_q;
        nack_d  = nack_q;
        scl_d   = scl_q;
        oe_d    = oe_q;
        ready_d = 1'h0;
        done_d  = 1'h0;
        if (reset)
        begin
            state_d = HS_WAKE;
            tick_d  = '0;
            phase_d = 2'h0;
            bit_d   = 4'h0;
            shift_d = 8'h00;
            last_d  = 1'h0;
            nack_d  = 1'h0;
            scl_d   = 1'h1;
            oe_d    = 1'h0;
        end
        else
        begin
            unique case (state_q)
                HS_WAKE:
                    // clock pulses with data moving only while clock is low
                    if (tick)
                    begin
                        scl_d = (phase_q == 2'h0) || (phase_q == 2'h1);
                        if (phase_q == 2'h3)
                        begin
                            oe_d  = ~oe_q;
                            bit_d = bit_q + 4'h1;
                            if (bit_q == WAKE_LAST)
                            begin
                                oe_d    = 1'h0;
                                state_d = HS_IDLE;
                            end
                        end
                    end
                HS_IDLE:
                begin
                    scl_d   = 1'h1;
                    oe_d    = 1'h0;                 // [R13]
                    tick_d  = '0;
                    phase_d = 2'h0;
                    if (xfer_valid)
                    begin
                        state_d = HS_START;
                        nack_d  = 1'h0;
                        bit_d   = 4'h0;
                        last_d  = 1'h0;
                        shift_d = {`AIC_ADDR_FIXED, target_id, `AIC_ADDR_WRITE};
                    end
                end
                HS_START:
                    if (tick)
                    begin
                        if (phase_q == 2'h0)
                            oe_d = 1'h1;            // [R4]
                        else
                        begin
                            scl_d   = 1'h0;
                            phase_d = 2'h0;
                            state_d = HS_BIT;
                        end
                    end
                HS_BIT:
                    if (tick)
                    begin
                        unique case (phase_q)
                            2'h0:
                                // data changes only while the clock is low
                                oe_d = (bit_q == `AIC_ACK_SLOT) ? 1'h0 : ~shift_q[7];   // [R6] [R7] [R9]
                            2'h1:
                                scl_d = 1'h1;
                            2'h2:
                                if (bit_q == `AIC_ACK_SLOT)
                                    nack_d = sda_s;                 // [R10]
                            2'h3:
                            begin
                                scl_d = 1'h0;
                                if (bit_q != `AIC_ACK_SLOT)
                                begin
                                    shift_d = {shift_q[6:0], 1'h0};
                                    bit_d   = bit_q + 4'h1;
                                end
                                else if (nack_q || last_q)
                                    state_d = HS_STOP;              // [R8]
                                else if (xfer_valid)
                                begin
                                    shift_d = xfer_data;            // [R11]
                                    last_d  = xfer_last;
                                    ready_d = 1'h1;
                                    bit_d   = 4'h0;
                                end
                                else
                                    phase_d = phase_q;              // hold clock low until data
                            end
                        endcase
                    end
                HS_STOP:
                    if (tick)
                    begin
                        unique case (phase_q)
                            2'h0: oe_d  = 1'h1;
                            2'h1: scl_d = 1'h1;
                            2'h2: oe_d  = 1'h0;                     // [R12]
                            2'h3:
                            begin
                                done_d  = 1'h1;
                                state_d = HS_IDLE;
                            end
                        endcase
                    end
                default:
                    state_d = HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        state_q <= state_d;
        tick_q  <= tick_d;
        phase_q <= phase_d;
        bit_q   <= bit_d;
        shift_q <= shift_d;
        last_q  <= last_d;
        nack_q  <= nack_d;
        scl_q   <= scl_d;
        oe_q    <= oe_d;
        ready_q <= ready_d;
        done_q  <= done_d;
    end

    assign bus.scl         = scl_q;
    assign bus.host_sda_oe = oe_q;
    assign xfer_ready      = ready_q;
    assign xfer_done       = done_q;
    assign xfer_nack       = nack_q;

endmodule // aic_host_end

// ==== tb/aic_link_chk.sv ====
// assertions on the two-wire link between host end and device end
`timescale 1ns/100ps

module aic_link_chk
    import aic_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    // ==========================================
    // frame tracking
    logic       scl_q, sda_q, frm_q, frm_d, fst_q, fst_d, adr_q, adr_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    wire        rise = scl & ~scl_q;
    wire        hi   = scl & scl_q;

    always_comb
    begin
        frm_d = frm_q;
        fst_d = fst_q;
        adr_d = adr_q;
        cnt_d = cnt_q;
        sh_d  = sh_q;
        if (rise)
        begin
            sh_d  = {sh_q[6:0], sda};
            cnt_d = (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
            fst_d = (cnt_q == 4'h8) ? 1'b0 : fst_q;
            adr_d = adr_q | (fst_q & (cnt_q == 4'h8) & dev_sda_oe);
        end
        if (hi & sda_q & ~sda)
        begin
            frm_d = 1'b1;
            fst_d = 1'b1;
            adr_d = 1'b0;
            cnt_d = 4'h0;
        end
        if (hi & ~sda_q & sda)
        begin
            frm_d = 1'b0;
            fst_d = 1'b0;
            adr_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        scl_q <= reset | scl;
        sda_q <= reset | sda;
        frm_q <= ~reset & frm_d;
        fst_q <= ~reset & fst_d;
        adr_q <= ~reset & adr_d;
        cnt_q <= reset ? 4'h0 : cnt_d;
        sh_q  <= reset ? 8'h00 : sh_d;
    end

    // ==========================================
    // link rules
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    oe_scl_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device enable changed with clock high");
    oe_in_slot_a: assert property (rise && dev_sda_oe |-> cnt_q == 4'h8)
        else $error("device pulled data outside acknowledge slot");
    addr_match_a: assert property (rise && fst_q && cnt_q == 4'h8 && dev_sda_oe |-> sh_q[7:2] == 6'h36 && !sh_q[0])
        else $error("device acknowledged a foreign address");
    data_ack_a: assert property (rise && adr_q && cnt_q == 4'h8 |-> dev_sda_oe && !sda)
        else $error("data byte not acknowledged");
    silent_dev_a: assert property (!adr_q && !fst_q |-> !dev_sda_oe)
        else $error("unaddressed device drove data");
    idle_high_a: assert property (!frm_q && !$fell(sda) |-> sda)
        else $error("data low while bus idle");
    bit_stable_a: assert property (rise |-> $stable(sda) [*4])
        else $error("data moved while clock high");
    ack_pulse_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8] ##[1:40] !dev_sda_oe)
        else $error("acknowledge pulse length wrong");
    host_rel_a: assert property (rise && cnt_q == 4'h8 |-> !host_sda_oe)
        else $error("host drove data in acknowledge slot");

    cover property (rise && fst_q && cnt_q == 4'h8 && dev_sda_oe);
    cover property (rise && fst_q && cnt_q == 4'h8 && !dev_sda_oe);
    cover property (rise && adr_q && cnt_q == 4'h8);
endmodule // aic_link_chk

// ==== tb/tb_amp_i2c_control_slave.sv ====
// self-checking bench joining host end and device end
`timescale 1ns/100ps

module tb_amp_i2c_control_slave;
    logic       core_clk = 1'b0, host_rst = 1'b1, dev_rst = 1'b1, strap = 1'b0, chk_rst = 1'b1;
    logic       target_id = 1'b0, xfer_valid = 1'b0, xfer_last = 1'b0, dummy;
    logic [7:0] xfer_data = 8'h00, rx_byte, rx2_byte;
    logic       xfer_ready, xfer_done, xfer_nack, rx_valid, rx2_valid;
    logic       wb[$];
    logic [7:0] tx_q[$], rx_q[$], rx2_q[$];
    int         num_errors = 0, num_checks = 0, cyc = 0;

    aic_bus_if bus ();
    aic_bus_if bus2 ();

    aic_host_end #(.QUARTER_CYCLES(4), .WAKE_BITS(4)) i_aic_host_end (.bus(bus.host), .core_clk(core_clk),
        .reset(host_rst), .target_id(target_id), .xfer_valid(xfer_valid), .xfer_data(xfer_data),
        .xfer_last(xfer_last), .xfer_ready(xfer_ready), .xfer_done(xfer_done), .xfer_nack(xfer_nack));
    aic_dev_end i_aic_dev_end (.bus(bus.dev), .core_clk(core_clk), .reset(dev_rst),
        .chip_identity_strap(strap), .rx_byte(rx_byte), .rx_valid(rx_valid));
    aic_dev_end i_aic_dev_end2 (.bus(bus2.dev), .core_clk(core_clk), .reset(dev_rst),
        .chip_identity_strap(1'b0), .rx_byte(rx2_byte), .rx_valid(rx2_valid));
    aic_link_chk i_aic_link_chk (.core_clk(core_clk), .reset(chk_rst), .scl(bus.scl),
        .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe), .sda(bus.sda));

    always #50 core_clk = ~core_clk;

    // ==========================================
    // monitors and hang guard
    always @(negedge bus.sda) if (bus.scl === 1'b1) wb.delete();
    always @(posedge bus.scl) wb.push_back(bus.sda);
    always @(posedge core_clk)
    begin
        if (rx_valid === 1'b1)
            rx_q.push_back(rx_byte);
        if (rx2_valid === 1'b1)
            rx2_q.push_back(rx2_byte);
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            num_errors++;
            $display("[ERR] run length expected finish seen hang");
            stop_test();
        end
    end

    // ==========================================
    // compares and drivers
    task automatic chk1(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic xfer(input logic id);
        int   t;
        logic fin;
        fin = 1'b0;
        rx_q.delete();
        target_id = id;
        foreach (tx_q[i])
        begin
            if (!fin)
            begin
                xfer_valid = 1'b1;
                xfer_data  = tx_q[i];
                xfer_last  = (i == tx_q.size() - 1);
                t = 0;
                do
                begin
                    @(posedge core_clk);
                    t++;
                    fin = (xfer_done === 1'b1);
                    // refused: withdraw so the host does not restart after done
                    if (t > 1 && xfer_nack === 1'b1)
                        xfer_valid <= 1'b0;
                end
                while (xfer_ready !== 1'b1 && !fin && t < 3000);
                #2;
            end
        end
        xfer_valid = 1'b0;
        t = 0;
        while (!fin && t < 3000)
        begin
            @(posedge core_clk);
            t++;
            fin = (xfer_done === 1'b1);
        end
        repeat (8) @(posedge core_clk);
        #2;
        chk1("done", 1'b1, fin);
    endtask

    // bits seen on the wire: address, its ack, then each byte and ack
    task automatic chk_wire(input logic [7:0] a, input logic ak, input int nb);
        logic [8:0] u;
        for (int k = 0; k <= nb; k++)
        begin
            u = (k == 0) ? {a, ak} : {tx_q[k-1], 1'b0};
            for (int j = 0; j < 9; j++)
                chk1("wire bit", u[8-j], wb[9*k+j]);
        end
    endtask

    task automatic bb_bit(input logic b, output logic s);
        bus2.host_sda_oe = ~b;
        #40;
        bus2.scl = 1'b1;
        #40;
        s = bus2.sda;
        #40;
        bus2.scl = 1'b0;
        #40;
    endtask

    task automatic bb_byte(input logic [7:0] v, input int n, output logic ak);
        for (int j = 7; j > 7 - n; j--)
            bb_bit(v[j], ak);
        if (n == 8)
            bb_bit(1'b1, ak);
    endtask

    // start when set, stop otherwise
    task automatic bb_frame(input logic start);
        bus2.host_sda_oe = ~start;
        #40;
        bus2.scl = 1'b1;
        #40;
        bus2.host_sda_oe = start;
        #40;
        if (start)
            bus2.scl = 1'b0;
        #40;
    endtask

    // ==========================================
    // scenarios
    task automatic test_strap(input logic s);
        strap = s;
        tx_q = '{8'h81};
        xfer(s);
        chk1("nack", 1'b0, xfer_nack);
        chk8("rx byte", 8'h81, rx_q[0]);
        chk_wire({6'h36, s, 1'b0}, 1'b0, 1);
        xfer(~s);
        chk1("nack", 1'b1, xfer_nack);
        chk8("rx count", 8'h00, 8'(rx_q.size()));
        chk_wire({6'h36, ~s, 1'b0}, 1'b1, 0);
        $display("test strap %b done", s);
    endtask

    task automatic test_multi();
        strap = 1'b0;
        tx_q = '{8'ha5, 8'h3c, 8'hff, 8'h00};
        xfer(1'b0);
        chk1("nack", 1'b0, xfer_nack);
        chk8("rx count", 8'h04, 8'(rx_q.size()));
        foreach (tx_q[i])
            chk8("rx byte", tx_q[i], rx_q[i]);
        chk_wire({6'h36, 2'b00}, 1'b0, 4);
        chk1("idle data", 1'b1, bus.sda);
        chk1("idle clock", 1'b1, bus.scl);
        $display("test multi done");
    endtask

    task automatic test_link2();
        logic ak;
        rx2_q.delete();
        bb_frame(1'b1);
        bb_byte({6'h36, 2'b01}, 8, ak);
        chk1("read addr ack", 1'b1, ak);
        bb_byte(8'h77, 8, ak);
        chk1("ignored ack", 1'b1, ak);
        bb_frame(1'b1);
        bb_byte({6'h36, 2'b00}, 8, ak);
        chk1("addr ack", 1'b0, ak);
        bb_byte(8'h5a, 8, ak);
        chk1("data ack", 1'b0, ak);
        bb_byte(8'hc3, 5, ak);
        bb_frame(1'b0);
        repeat (10) @(posedge core_clk);
        chk8("rx2 count", 8'h01, 8'(rx2_q.size()));
        chk8("rx2 byte", 8'h5a, rx2_q[0]);
        chk1("rx2 idle", 1'b1, bus2.sda);
        $display("test link2 done");
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        bus2.scl = 1'b1;
        bus2.host_sda_oe = 1'b0;
        repeat (4) @(posedge core_clk);
        #2;
        // second device: link reset taken, both event toggles cleared
        bb_byte(8'h55, 6, dummy);
        host_rst = 1'b0;
        // first device: release between wake clocks so link reset clears before idle
        repeat (2) @(posedge bus.scl);
        @(posedge core_clk);
        #2;
        dev_rst = 1'b0;
        bb_byte(8'h55, 2, dummy);
        bb_frame(1'b0);
        repeat (100) @(posedge core_clk);
        #2;
        chk_rst = 1'b0;
        repeat (4) @(posedge core_clk);
        #2;
        test_strap(1'b0);
        test_strap(1'b1);
        test_multi();
        test_link2();
        stop_test();
    end
endmodule // tb_amp_i2c_control_slave
